// File: core/rx_stream_packet_sequencer.sv
`include "rx_stream_regs.svh"

module rx_stream_packet_sequencer (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Sample FIFO read side
    input wire logic sample_fifo_prog_empty,
    input wire logic [15:0] sample_fifo_data,
    output logic sample_fifo_pop,
    // Header ROM, one cycle read latency
    output logic [5:0] header_rom_addr,
    input wire logic [7:0] header_rom_data,
    // Packet byte FIFO write side
    input wire logic [15:0] packet_fifo_level,
    output logic [7:0] packet_fifo_data,
    output logic packet_fifo_push,
    output logic packet_fifo_ready,
    // Status toward the output multiplexer
    output logic [3:0] content_select_out,
    output logic byte_phase,
    output logic group_done,
    output logic [1:0] fsm_fault_flags
);

    // ------------------------------------------------------------
    // Control and status
    // ------------------------------------------------------------
    logic enable;
    logic fault_clear;
    logic fill_threshold_reached;
    logic [15:0] group_count;

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic aw_got;
    logic w_got;
    logic [3:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic do_write;
    logic [31:0] read_word;
    logic read_hit;

    rx_stream_pkg::seq_state_t seq_state;
    rx_stream_pkg::build_state_t build_state;
    logic [1:0] packet_index;

    assign do_write = aw_got && w_got && !s_axi_bvalid;

    // Address and data are captured independently; the response waits for both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AXI_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_q[3:2] == `REG_CTRL >> 2) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Only the low byte lane of the control word carries bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable <= `CTRL_RESET_VALUE;
            fault_clear <= 1'b0;
        end else begin
            fault_clear <= 1'b0;
            if (do_write && aw_addr_q[3:2] == `REG_CTRL >> 2 && w_strb_q[0]) begin
                enable <= w_data_q[`CTRL_ENABLE_BIT];
                fault_clear <= w_data_q[`CTRL_FAULT_CLEAR_BIT];
            end
        end
    end

    always_comb begin
        read_hit = 1'b1;
        read_word = 32'h0000_0000;
        case (s_axi_araddr[3:2])
            2'h0: read_word = {31'h0000_0000, enable};
            2'h1: read_word = {20'h00000, 2'h0, packet_index, seq_state, packet_fifo_ready,
                               fill_threshold_reached, fsm_fault_flags};
            2'h2: read_word = {16'h0000, group_count};
            default: read_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `AXI_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= read_word;
            s_axi_rresp <= read_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Packet group sequencer
    // ------------------------------------------------------------
    logic packet_complete;
    logic build_start;
    logic seq_fault_set;
    logic build_fault_set;

    // Registered so the FIFO flag never feeds the state decode directly
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fill_threshold_reached <= 1'b0;
        end else begin
            fill_threshold_reached <= !sample_fifo_prog_empty;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seq_state <= rx_stream_pkg::seq_idle;
            packet_index <= 2'h0;
            build_start <= 1'b0;
            group_done <= 1'b0;
            seq_fault_set <= 1'b0;
        end else begin
            build_start <= 1'b0;
            group_done <= 1'b0;
            seq_fault_set <= 1'b0;
            case (seq_state)
                rx_stream_pkg::seq_idle: begin
                    packet_index <= 2'h0;
                    if (enable) begin
                        seq_state <= rx_stream_pkg::wait_fill_state;
                    end
                end
                rx_stream_pkg::wait_fill_state: begin
                    if (enable && fill_threshold_reached) begin
                        seq_state <= rx_stream_pkg::build_first_packet_state;
                        build_start <= 1'b1;
                    end else if (!enable) begin
                        seq_state <= rx_stream_pkg::seq_idle;
                    end
                end
                rx_stream_pkg::build_first_packet_state,
                rx_stream_pkg::build_second_packet_state,
                rx_stream_pkg::build_third_packet_state,
                rx_stream_pkg::build_fourth_packet_state: begin
                    if (packet_complete) begin
                        seq_state <= rx_stream_pkg::pause_stop_state;
                    end
                end
                rx_stream_pkg::pause_stop_state: begin
                    seq_state <= rx_stream_pkg::pause_done_state;
                end
                rx_stream_pkg::pause_done_state: begin
                    if ({2'b00, packet_index} == `PACKETS_PER_GROUP - 4'd1) begin
                        seq_state <= rx_stream_pkg::seq_idle;
                        group_done <= 1'b1;
                    end else begin
                        packet_index <= packet_index + 2'h1;
                        seq_state <= rx_stream_pkg::seq_state_t'(seq_state_next_build(packet_index));
                        build_start <= 1'b1;
                    end
                end
                default: begin
                    seq_fault_set <= 1'b1;
                    seq_state <= rx_stream_pkg::seq_idle;
                end
            endcase
        end
    end

    function automatic logic [3:0] seq_state_next_build(input logic [1:0] index);
        seq_state_next_build = 4'(rx_stream_pkg::build_second_packet_state) + {2'b00, index};
    endfunction : seq_state_next_build

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            group_count <= 16'h0000;
        end else if (group_done) begin
            group_count <= group_count + 16'h0001;
        end
    end

    // Set wins over a clear in the same cycle so no fault is lost
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fsm_fault_flags <= 2'b00;
        end else begin
            if (fault_clear) begin
                fsm_fault_flags <= 2'b00;
            end
            if (seq_fault_set) begin
                fsm_fault_flags[0] <= 1'b1;
            end
            if (build_fault_set) begin
                fsm_fault_flags[1] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Packet builder
    // ------------------------------------------------------------
    logic [10:0] byte_count;
    logic [3:0] packet_sel;
    logic a_req;
    logic [3:0] a_sel;
    logic a_pop;

    // Two-bit packet index, zero-extended to four bits, picks the data header code
    assign packet_sel = {2'b00, packet_index};
    assign packet_complete = (build_state == rx_stream_pkg::packet_end_state);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            build_state <= rx_stream_pkg::build_idle;
            byte_count <= 11'h000;
            build_fault_set <= 1'b0;
        end else begin
            build_fault_set <= 1'b0;
            case (build_state)
                rx_stream_pkg::build_idle: begin
                    byte_count <= 11'h000;
                    if (build_start) begin
                        build_state <= rx_stream_pkg::eth_header_state;
                    end
                end
                rx_stream_pkg::eth_header_state: begin
                    if (byte_count == {4'h0, `ETH_HDR_BYTES} - 11'h001) begin
                        byte_count <= 11'h000;
                        build_state <= rx_stream_pkg::payload_header_state;
                    end else begin
                        byte_count <= byte_count + 11'h001;
                    end
                end
                rx_stream_pkg::payload_header_state: begin
                    if (byte_count == {9'h000, `PAYLOAD_HDR_BYTES} - 11'h001) begin
                        byte_count <= 11'h000;
                        build_state <= rx_stream_pkg::sample_copy_state;
                    end else begin
                        byte_count <= byte_count + 11'h001;
                    end
                end
                rx_stream_pkg::sample_copy_state: begin
                    if (byte_count == `PAYLOAD_SAMPLE_BYTES - 11'h001) begin
                        build_state <= rx_stream_pkg::packet_end_state;
                    end else begin
                        byte_count <= byte_count + 11'h001;
                    end
                end
                rx_stream_pkg::packet_end_state: begin
                    build_state <= rx_stream_pkg::build_idle;
                end
                default: begin
                    build_fault_set <= 1'b1;
                    build_state <= rx_stream_pkg::build_idle;
                end
            endcase
        end
    end

    always_comb begin
        a_req = 1'b0;
        a_sel = `SEL_ETH_HDR;
        a_pop = 1'b0;
        case (build_state)
            rx_stream_pkg::eth_header_state: begin
                a_req = 1'b1;
                a_sel = `SEL_ETH_HDR;
            end
            rx_stream_pkg::payload_header_state: begin
                a_req = 1'b1;
                a_sel = `SEL_DATA_HDR_BASE + packet_sel;
            end
            rx_stream_pkg::sample_copy_state: begin
                a_req = 1'b1;
                a_sel = `SEL_SAMPLES;
                a_pop = !byte_count[0];
            end
            default: begin
                a_req = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Byte pipeline: stage A drives ROM and FIFO, stage B writes bytes
    // ------------------------------------------------------------
    logic req_a;
    logic [1:0] hdr_idx_a;
    logic req_d;
    logic [3:0] sel_d;
    logic phase_d;
    logic [1:0] hdr_idx_d;
    logic [7:0] low_byte_hold;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_a <= 1'b0;
            hdr_idx_a <= 2'h0;
            header_rom_addr <= 6'h00;
            content_select_out <= `SEL_ETH_HDR;
            sample_fifo_pop <= 1'b0;
            byte_phase <= 1'b0;
        end else begin
            req_a <= a_req;
            hdr_idx_a <= byte_count[1:0];
            content_select_out <= a_sel;
            sample_fifo_pop <= a_pop;
            byte_phase <= (build_state == rx_stream_pkg::sample_copy_state) && byte_count[0];
            if (build_state == rx_stream_pkg::eth_header_state) begin
                header_rom_addr <= byte_count[5:0];
            end
        end
    end

    // ROM data and popped words arrive one cycle after stage A
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_d <= 1'b0;
            sel_d <= `SEL_ETH_HDR;
            phase_d <= 1'b0;
            hdr_idx_d <= 2'h0;
        end else begin
            req_d <= req_a;
            sel_d <= content_select_out;
            phase_d <= byte_phase;
            hdr_idx_d <= hdr_idx_a;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            packet_fifo_push <= 1'b0;
            packet_fifo_data <= 8'h00;
            low_byte_hold <= 8'h00;
        end else begin
            packet_fifo_push <= req_d;
            if (sel_d == `SEL_ETH_HDR) begin
                packet_fifo_data <= header_rom_data;
            end else if (sel_d == `SEL_SAMPLES) begin
                // High byte first, low byte held for the next phase
                if (!phase_d) begin
                    packet_fifo_data <= sample_fifo_data[15:8];
                    low_byte_hold <= sample_fifo_data[7:0];
                end else begin
                    packet_fifo_data <= low_byte_hold;
                end
            end else begin
                case (hdr_idx_d)
                    2'h0: packet_fifo_data <= `PAYLOAD_HDR_MARK;
                    2'h1: packet_fifo_data <= `PAYLOAD_HDR_ID;
                    default: packet_fifo_data <= {4'h0, sel_d - `SEL_DATA_HDR_BASE} + 8'h01;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Downstream ready
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            packet_fifo_ready <= 1'b0;
        end else begin
            packet_fifo_ready <= (packet_fifo_level >= `PACKET_FIFO_READY_BYTES);
        end
    end

endmodule : rx_stream_packet_sequencer

// File: core/rx_stream_pkg.sv
package rx_stream_pkg;

    typedef enum logic [3:0] {
        seq_idle = 4'h0,
        wait_fill_state = 4'h1,
        build_first_packet_state = 4'h2,
        build_second_packet_state = 4'h3,
        build_third_packet_state = 4'h4,
        build_fourth_packet_state = 4'h5,
        pause_stop_state = 4'h6,
        pause_done_state = 4'h7
    } seq_state_t;

    typedef enum logic [2:0] {
        build_idle = 3'h0,
        eth_header_state = 3'h1,
        payload_header_state = 3'h2,
        sample_copy_state = 3'h3,
        packet_end_state = 3'h4
    } build_state_t;

endpackage : rx_stream_pkg

// File: core/rx_stream_regs.svh
`ifndef RX_STREAM_REGS_SVH
`define RX_STREAM_REGS_SVH

// Register map, byte addresses
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_GROUPS 4'h8
`define CTRL_ENABLE_BIT 0
`define CTRL_FAULT_CLEAR_BIT 1
`define CTRL_RESET_VALUE 1'b0
`define AXI_RESP_OKAY 2'b00
`define AXI_RESP_SLVERR 2'b10

// Packet layout
`define ETH_HDR_BYTES 7'd42
`define PAYLOAD_HDR_BYTES 2'd3
`define PAYLOAD_SAMPLE_BYTES 11'd480
`define PAYLOAD_HDR_MARK 8'h55
`define PAYLOAD_HDR_ID 8'h00
`define PACKETS_PER_GROUP 4'd4
`define PACKET_FIFO_READY_BYTES 16'd3000

// Content select codes
`define SEL_ETH_HDR 4'h0
`define SEL_SAMPLES 4'h1
`define SEL_DATA_HDR_BASE 4'h2
`endif

// File: sim/rx_stream_far_side.sv
module rx_stream_far_side (
    // Clock, reset, fill control
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic filled,
    // Sample FIFO
    input wire logic sample_fifo_pop,
    output logic sample_fifo_prog_empty,
    output logic [15:0] sample_fifo_data,
    // Header ROM
    input wire logic [5:0] header_rom_addr,
    output logic [7:0] header_rom_data,
    // Packet byte FIFO
    input wire logic packet_fifo_push,
    output logic [15:0] packet_fifo_level
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] word;
    assign sample_fifo_prog_empty = ~filled;
    // Words count up; between pops the bus churns so stale data is never valid
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            word <= 16'h0000;
            sample_fifo_data <= 16'h0000;
        end else if (sample_fifo_pop) begin
            word <= word + 16'h0001;
            sample_fifo_data <= word;
        end else begin
            sample_fifo_data <= ~sample_fifo_data;
        end
    end
    always_ff @(posedge aclk) begin
        header_rom_data <= {2'b10, header_rom_addr};
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            packet_fifo_level <= 16'h0000;
        end else begin
            packet_fifo_level <= packet_fifo_level + {15'h0000, packet_fifo_push};
        end
    end
endmodule : rx_stream_far_side

// File: sim/rx_stream_packet_sequencer_properties.sv
module rx_stream_seq_properties (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Stream side
    input wire logic sample_fifo_pop,
    input wire logic [5:0] header_rom_addr,
    input wire logic [15:0] packet_fifo_level,
    input wire logic packet_fifo_push,
    input wire logic packet_fifo_ready,
    input wire logic [3:0] content_select_out,
    input wire logic byte_phase,
    input wire logic group_done,
    input wire logic [1:0] fsm_fault_flags
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_push_start;
        $rose(packet_fifo_push);
    endsequence
    sequence s_push_run;
        packet_fifo_push [*8];
    endsequence
    sequence s_word_bytes;
        ##2 packet_fifo_push ##1 packet_fifo_push;
    endsequence
    property p_pop_rate;
        sample_fifo_pop |=> !sample_fifo_pop;
    endproperty
    property p_phase;
        sample_fifo_pop |-> !byte_phase ##1 byte_phase;
    endproperty
    property p_word_bytes;
        sample_fifo_pop |-> s_word_bytes;
    endproperty
    property p_push_burst;
        s_push_start |-> s_push_run;
    endproperty
    property p_ready;
        packet_fifo_ready == ($past(packet_fifo_level) >= 16'd3000);
    endproperty
    property p_group_pulse;
        group_done |=> !group_done [*8];
    endproperty
    property p_select;
        content_select_out <= 4'h5;
    endproperty
    property p_rom_step;
        ($changed(header_rom_addr) && header_rom_addr != 6'd0) |-> header_rom_addr == $past(header_rom_addr) + 6'd1;
    endproperty
    property p_fault;
        fsm_fault_flags == 2'b00;
    endproperty
    a_pop_rate: assert property (p_pop_rate) else $error("pop faster than half rate");
    a_phase: assert property (p_phase) else $error("byte phase off");
    a_word_bytes: assert property (p_word_bytes) else $error("word not pushed as two bytes");
    a_push_burst: assert property (p_push_burst) else $error("push burst broken");
    a_ready: assert property (p_ready) else $error("ready wrong for level");
    a_group_pulse: assert property (p_group_pulse) else $error("group done too long");
    a_select: assert property (p_select) else $error("select out of range");
    a_rom_step: assert property (p_rom_step) else $error("rom address skipped");
    a_fault: assert property (p_fault) else $error("fault flag set");
endmodule : rx_stream_seq_properties
bind rx_stream_packet_sequencer rx_stream_seq_properties u_rx_stream_seq_properties (.*);

// File: sim/tb_rx_stream_packet_sequencer.sv
module tb_rx_stream_packet_sequencer;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic wr; logic [3:0] a; logic [31:0] d; logic [1:0] resp; logic [31:0] rd;} row_t;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic filled = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, fsm_fault_flags, r;
    logic sample_fifo_prog_empty, sample_fifo_pop, packet_fifo_push, packet_fifo_ready, byte_phase, group_done;
    logic [15:0] sample_fifo_data, packet_fifo_level;
    logic [5:0] header_rom_addr, seen = 6'h00;
    logic [7:0] header_rom_data, packet_fifo_data;
    logic [3:0] content_select_out;
    int fails = 0, n_checks = 0, nbytes = 0;
    row_t rows[10] = '{'{0, 4'h0, 0, 2'b00, 0}, '{0, 4'h4, 0, 2'b00, 0}, '{0, 4'h8, 0, 2'b00, 0},
        '{0, 4'hc, 0, 2'b10, 0}, '{1, 4'hc, 1, 2'b10, 0}, '{1, 4'h4, 32'hffff, 2'b10, 0},
        '{1, 4'h8, 32'hffff, 2'b10, 0}, '{0, 4'h8, 0, 2'b00, 0}, '{1, 4'h0, 3, 2'b00, 0}, '{0, 4'h0, 0, 2'b00, 1}};
    always #2 aclk = ~aclk;
    rx_stream_packet_sequencer u_rx_stream_packet_sequencer (.*);
    rx_stream_far_side u_rx_stream_far_side (.*);
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask : check
    task automatic axw(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axw
    task automatic axr(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        r = s_axi_rresp;
        q = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask : axr
    task automatic wait_group();
        do @(posedge aclk); while (group_done !== 1'b1);
    endtask : wait_group
    function automatic logic [7:0] exp_byte(input int n);
        int i;
        int s;
        logic [15:0] w;
        i = n % 525;
        s = (n / 525) * 480 + i - 45;
        w = 16'(s / 2);
        if (i < 42) return {2'b10, 6'(i)};
        if (i == 42) return 8'h55;
        if (i == 43) return 8'h00;
        if (i == 44) return 8'(n / 525 % 4 + 1);
        return (s % 2 == 0) ? w[15:8] : w[7:0];
    endfunction : exp_byte
    task automatic results();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    // ------------------------------------------------------------
    // Byte stream monitor, sequence restarts with each reset
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            nbytes = 0;
        end else begin
            seen[content_select_out] = 1'b1;
            if (packet_fifo_push === 1'b1) begin
                check(packet_fifo_data, exp_byte(nbytes), "byte");
                nbytes++;
            end
        end
    end
    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        results();
    end
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        check({s_axi_awready, s_axi_wready, s_axi_arready, packet_fifo_push, sample_fifo_pop}, 5'b11100, "reset");
        foreach (rows[k]) begin
            if (rows[k].wr) axw(rows[k].a, rows[k].d);
            else axr(rows[k].a);
            if (!rows[k].wr) check(q, rows[k].rd, "rdata");
            check(r, rows[k].resp, "resp");
        end
        check(fsm_fault_flags, 2'b00, "faults");
        $display("test registers done");
        repeat (20) @(posedge aclk);
        check(nbytes, 0, "built before fill");
        filled <= 1'b1;
        wait_group();
        check(nbytes, 2100, "group size");
        check(seen, 6'h3f, "selects");
        axr(4'h8);
        check(q, 1, "groups");
        while (nbytes < 4100) @(posedge aclk);
        filled <= 1'b0;
        wait_group();
        check(packet_fifo_ready, 1, "ready");
        repeat (100) @(posedge aclk);
        check(nbytes, 4200, "stop at wait fill");
        axr(4'h4);
        check(q[7:0], 8'h18, "status");
        axw(4'h0, 0);
        axr(4'h4);
        check(q[7:4], 4'h0, "abort to idle");
        $display("test groups done");
        axw(4'h0, 1);
        filled <= 1'b1;
        // Count already stands at 4200, so wait until the third group is well into its first packet
        while (nbytes < 4500) @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        check({packet_fifo_push, sample_fifo_pop, group_done, packet_fifo_ready}, 4'h0, "mid reset");
        aresetn <= 1'b1;
        repeat (50) @(posedge aclk);
        check(nbytes, 0, "no build after reset");
        axr(4'h0);
        check(q, 0, "ctrl after reset");
        $display("test reset done");
        results();
    end
endmodule : tb_rx_stream_packet_sequencer
